// [rtl/pog_bank.sv]
/*
 Pad override bank: two lane registers over AXI4-Lite, pad control muxing.
 Assumes pad inputs are asynchronous and native controls come from clk_i logic.
*/
`timescale 1ns/1ps
module pog_bank #(
	parameter int unsigned NUM_PADS = pog_pkg::NUM_PADS
) (
	// Clock and reset
	input  wire logic                        clk_i,
	input  wire logic                        sys_rst_i,
	input  wire logic                        clk_en_i,
	// AXI4-Lite write
	input  wire logic [9:0]                  s_axi_awaddr_i,
	input  wire logic                        s_axi_awvalid_i,
	output logic                             s_axi_awready_o,
	input  wire logic [31:0]                 s_axi_wdata_i,
	input  wire logic [3:0]                  s_axi_wstrb_i,
	input  wire logic                        s_axi_wvalid_i,
	output logic                             s_axi_wready_o,
	output logic [1:0]                       s_axi_bresp_o,
	output logic                             s_axi_bvalid_o,
	input  wire logic                        s_axi_bready_i,
	// AXI4-Lite read
	input  wire logic [9:0]                  s_axi_araddr_i,
	input  wire logic                        s_axi_arvalid_i,
	output logic                             s_axi_arready_o,
	output logic [31:0]                      s_axi_rdata_o,
	output logic [1:0]                       s_axi_rresp_o,
	output logic                             s_axi_rvalid_o,
	input  wire logic                        s_axi_rready_i,
	// Pads: pulse pads 1-6 then test pads 0-1
	input  wire logic [NUM_PADS-1:0]         pad_in_i,
	input  pog_pkg::pog_pad_ctl_t [NUM_PADS-1:0] native_ctl_i,
	output pog_pkg::pog_pad_ctl_t [NUM_PADS-1:0] pad_ctl_o
);
	// The lane map below is wired for exactly eight pads
	if (NUM_PADS != 8) begin : g_bad_pads
		$error("pog_bank serves exactly eight pads");
	end

	pog_pkg::pog_lane_t [NUM_PADS-1:0] lane;
	logic [NUM_PADS-1:0] sync_a;
	logic [NUM_PADS-1:0] sync_b;
	logic [NUM_PADS-1:0] pad_sampled_input;
	logic [9:0]  aw_addr;
	logic        aw_held;
	logic [31:0] w_data;
	logic [3:0]  w_strb;
	logic        w_held;

	// Pad inputs cross into the clock domain before sampling
	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			sync_a <= '0;
			sync_b <= '0;
			pad_sampled_input <= '0;
		end else if (clk_en_i) begin
			sync_a <= pad_in_i;
			sync_b <= sync_a;
			pad_sampled_input <= sync_b;
		end
	end

	function automatic logic [7:0] lane_word(input pog_pkg::pog_lane_t l, input logic s);
		lane_word = {1'b0, s, l};
	endfunction

	function automatic logic bank_hit(input logic [9:0] addr, input logic [7:0] idx);
		bank_hit = addr[9:2] == idx;
	endfunction

	wire [31:0] word_a = {lane_word(lane[3], pad_sampled_input[3]),
		lane_word(lane[2], pad_sampled_input[2]),
		lane_word(lane[1], pad_sampled_input[1]),
		lane_word(lane[0], pad_sampled_input[0])};
	wire [31:0] word_b = {lane_word(lane[7], pad_sampled_input[7]),
		lane_word(lane[6], pad_sampled_input[6]),
		lane_word(lane[5], pad_sampled_input[5]),
		lane_word(lane[4], pad_sampled_input[4])};

	// Write channel: address and data may arrive in either order
	wire aw_take  = s_axi_awvalid_i && s_axi_awready_o;
	wire w_take   = s_axi_wvalid_i && s_axi_wready_o;
	wire wr_go    = aw_held && w_held && !s_axi_bvalid_o;
	wire wr_hit_a = bank_hit(aw_addr, pog_pkg::IDX_BANK_A);
	wire wr_hit_b = bank_hit(aw_addr, pog_pkg::IDX_BANK_B);
	wire ar_take  = s_axi_arvalid_i && s_axi_arready_o;
	wire rd_hit_a = bank_hit(s_axi_araddr_i, pog_pkg::IDX_BANK_A);
	wire rd_hit_b = bank_hit(s_axi_araddr_i, pog_pkg::IDX_BANK_B);

	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			aw_held <= 1'b0;
			w_held <= 1'b0;
			aw_addr <= 10'h000;
			w_data <= 32'h0000_0000;
			w_strb <= 4'h0;
			s_axi_awready_o <= 1'b0;
			s_axi_wready_o <= 1'b0;
			s_axi_bvalid_o <= 1'b0;
			s_axi_bresp_o <= pog_pkg::RESP_OKAY;
		end else if (clk_en_i) begin
			s_axi_awready_o <= !aw_held && !aw_take && !s_axi_bvalid_o;
			s_axi_wready_o <= !w_held && !w_take && !s_axi_bvalid_o;
			if (aw_take) begin
				aw_held <= 1'b1;
				aw_addr <= s_axi_awaddr_i;
			end
			if (w_take) begin
				w_held <= 1'b1;
				w_data <= s_axi_wdata_i;
				w_strb <= s_axi_wstrb_i;
			end
			if (wr_go) begin
				aw_held <= 1'b0;
				w_held <= 1'b0;
				s_axi_bvalid_o <= 1'b1;
				s_axi_bresp_o <= (wr_hit_a || wr_hit_b) ? pog_pkg::RESP_OKAY
					: pog_pkg::RESP_SLVERR;
			end else if (s_axi_bvalid_o && s_axi_bready_i) begin
				s_axi_bvalid_o <= 1'b0;
			end
		end
	end

	// Lane storage; only bits 0-5 of each lane are writable
	for (genvar p = 0; p < 8; p++) begin : g_lane
		localparam int unsigned BYTE = p % 4;
		wire hit = (p < 4) ? wr_hit_a : wr_hit_b;
		always_ff @(posedge clk_i) begin
			if (sys_rst_i) begin
				lane[p] <= pog_pkg::pog_lane_t'(pog_pkg::LANE_RESET[5:0]);
			end else if (clk_en_i && wr_go && hit && w_strb[BYTE]) begin
				lane[p] <= pog_pkg::pog_lane_t'(w_data[BYTE*8 +: 6]);
			end
		end
		// Override chooses software settings, otherwise native function
		always_ff @(posedge clk_i) begin
			if (sys_rst_i) begin
				pad_ctl_o[p] <= '0;
			end else if (clk_en_i) begin
				if (lane[p].software_override) begin
					pad_ctl_o[p].drive_oe <= lane[p].drive_enable;
					pad_ctl_o[p].drive_level <= lane[p].output_level;
					pad_ctl_o[p].pullup_en <= !lane[p].weak_pullup_off;
					pad_ctl_o[p].pulldown_en <= lane[p].weak_pulldown_ctl;
					pad_ctl_o[p].schmitt_en <= lane[p].schmitt_enable;
				end else begin
					pad_ctl_o[p] <= native_ctl_i[p];
				end
			end
		end
	end

	// Read channel
	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			s_axi_arready_o <= 1'b0;
			s_axi_rvalid_o <= 1'b0;
			s_axi_rdata_o <= 32'h0000_0000;
			s_axi_rresp_o <= pog_pkg::RESP_OKAY;
		end else if (clk_en_i) begin
			s_axi_arready_o <= !s_axi_rvalid_o && !ar_take;
			if (ar_take) begin
				s_axi_rvalid_o <= 1'b1;
				s_axi_rdata_o <= rd_hit_a ? word_a : (rd_hit_b ? word_b : 32'h0000_0000);
				s_axi_rresp_o <= (rd_hit_a || rd_hit_b) ? pog_pkg::RESP_OKAY
					: pog_pkg::RESP_SLVERR;
			end else if (s_axi_rvalid_o && s_axi_rready_i) begin
				s_axi_rvalid_o <= 1'b0;
			end
		end
	end

	// Checks
	a_ovr_drive: assert property (@(posedge clk_i) disable iff (sys_rst_i)
		clk_en_i && lane[0].software_override |=> pad_ctl_o[0].drive_oe == $past(lane[0].drive_enable))
		else $error("override drive enable not applied");
	a_ovr_pullup: assert property (@(posedge clk_i) disable iff (sys_rst_i)
		clk_en_i && lane[1].software_override |=> pad_ctl_o[1].pullup_en != $past(lane[1].weak_pullup_off))
		else $error("pull-up polarity wrong");
	a_native_pass: assert property (@(posedge clk_i) disable iff (sys_rst_i)
		!sys_rst_i && clk_en_i && !lane[7].software_override
		|=> pad_ctl_o[7] == $past(native_ctl_i[7]))
		else $error("native control not passed");
	a_read_gap: assert property (@(posedge clk_i) disable iff (sys_rst_i)
		s_axi_rvalid_o |-> s_axi_rdata_o[7] == 1'b0 && s_axi_rdata_o[15] == 1'b0
		&& s_axi_rdata_o[23] == 1'b0 && s_axi_rdata_o[31] == 1'b0)
		else $error("unused bits read nonzero");
	a_lane_reset: assert property (@(posedge clk_i)
		sys_rst_i |=> lane[3] == pog_pkg::pog_lane_t'(pog_pkg::LANE_RESET[5:0]))
		else $error("lane reset value wrong");
	a_sample_lag: assert property (@(posedge clk_i) disable iff (sys_rst_i)
		!sys_rst_i && clk_en_i ##1 clk_en_i ##1 clk_en_i
		|=> pad_sampled_input[4] == $past(pad_in_i[4], 3))
		else $error("pad input not sampled");
	a_bank_a_read: assert property (@(posedge clk_i) disable iff (sys_rst_i)
		clk_en_i && ar_take && rd_hit_a |=> s_axi_rdata_o[5:0] == $past(lane[0]))
		else $error("bank a lane 0 misplaced");
	a_bank_b_read: assert property (@(posedge clk_i) disable iff (sys_rst_i)
		clk_en_i && ar_take && rd_hit_b |=> s_axi_rdata_o[29:24] == $past(lane[7]))
		else $error("test pad 1 lane misplaced");
	a_write_resp: assert property (@(posedge clk_i) disable iff (sys_rst_i)
		clk_en_i && wr_go && wr_hit_b |=> s_axi_bvalid_o && s_axi_bresp_o == pog_pkg::RESP_OKAY)
		else $error("bank b write not acknowledged");
	// Remaining override fields one lane each, then all fields on test pad 1, test pad 0 pull-up, pad 1 native pass
	a_ovr_level: assert property (@(posedge clk_i) disable iff (sys_rst_i)
		clk_en_i && lane[2].software_override
		|=> pad_ctl_o[2].drive_level == $past(lane[2].output_level))
		else $error("override level not applied");
	a_ovr_pulldown: assert property (@(posedge clk_i) disable iff (sys_rst_i)
		clk_en_i && lane[4].software_override
		|=> pad_ctl_o[4].pulldown_en == $past(lane[4].weak_pulldown_ctl))
		else $error("override pull-down not applied");
	a_ovr_schmitt: assert property (@(posedge clk_i) disable iff (sys_rst_i)
		clk_en_i && lane[5].software_override
		|=> pad_ctl_o[5].schmitt_en == $past(lane[5].schmitt_enable))
		else $error("override Schmitt enable not applied");
	a_test1_drive: assert property (@(posedge clk_i) disable iff (sys_rst_i)
		clk_en_i && lane[7].software_override
		|=> pad_ctl_o[7].drive_oe == $past(lane[7].drive_enable)
		&& pad_ctl_o[7].drive_level == $past(lane[7].output_level))
		else $error("test pad 1 drive not applied");
	a_test1_pulls: assert property (@(posedge clk_i) disable iff (sys_rst_i)
		clk_en_i && lane[7].software_override
		|=> pad_ctl_o[7].pullup_en != $past(lane[7].weak_pullup_off)
		&& pad_ctl_o[7].pulldown_en == $past(lane[7].weak_pulldown_ctl)
		&& pad_ctl_o[7].schmitt_en == $past(lane[7].schmitt_enable))
		else $error("test pad 1 pulls not applied");
	a_test0_pullup: assert property (@(posedge clk_i) disable iff (sys_rst_i)
		clk_en_i && lane[6].software_override
		|=> pad_ctl_o[6].pullup_en != $past(lane[6].weak_pullup_off))
		else $error("test pad 0 pull-up polarity wrong");
	a_native_idle: assert property (@(posedge clk_i) disable iff (sys_rst_i)
		!sys_rst_i && clk_en_i && !lane[0].software_override
		|=> pad_ctl_o[0] == $past(native_ctl_i[0]))
		else $error("pad 1 native control not passed");
	// Every lane lands in its own byte of the read word
	a_pad2_read: assert property (@(posedge clk_i) disable iff (sys_rst_i)
		clk_en_i && ar_take && rd_hit_a |=> s_axi_rdata_o[13:8] == $past(lane[1]))
		else $error("bank a lane 1 misplaced");
	a_pad3_read: assert property (@(posedge clk_i) disable iff (sys_rst_i)
		clk_en_i && ar_take && rd_hit_a |=> s_axi_rdata_o[21:16] == $past(lane[2]))
		else $error("bank a lane 2 misplaced");
	a_pad4_read: assert property (@(posedge clk_i) disable iff (sys_rst_i)
		clk_en_i && ar_take && rd_hit_a |=> s_axi_rdata_o[29:24] == $past(lane[3]))
		else $error("bank a lane 3 misplaced");
	a_pad5_read: assert property (@(posedge clk_i) disable iff (sys_rst_i)
		clk_en_i && ar_take && rd_hit_b |=> s_axi_rdata_o[5:0] == $past(lane[4]))
		else $error("bank b lane 0 misplaced");
	a_pad6_read: assert property (@(posedge clk_i) disable iff (sys_rst_i)
		clk_en_i && ar_take && rd_hit_b |=> s_axi_rdata_o[13:8] == $past(lane[5]))
		else $error("bank b lane 1 misplaced");
	a_test0_read: assert property (@(posedge clk_i) disable iff (sys_rst_i)
		clk_en_i && ar_take && rd_hit_b |=> s_axi_rdata_o[21:16] == $past(lane[6]))
		else $error("test pad 0 lane misplaced");
	a_input_read: assert property (@(posedge clk_i) disable iff (sys_rst_i)
		clk_en_i && ar_take && rd_hit_b
		|=> s_axi_rdata_o[30] == $past(pad_sampled_input[7]))
		else $error("test pad 1 input not read");
	a_bad_read: assert property (@(posedge clk_i) disable iff (sys_rst_i)
		clk_en_i && ar_take && !rd_hit_a && !rd_hit_b
		|=> s_axi_rdata_o == 32'h0000_0000 && s_axi_rresp_o == pog_pkg::RESP_SLVERR)
		else $error("unmapped read not refused");
	// Writes land only where they are mapped
	a_lane_write: assert property (@(posedge clk_i) disable iff (sys_rst_i)
		clk_en_i && wr_go && wr_hit_a && w_strb[0]
		|=> lane[0] == pog_pkg::pog_lane_t'($past(w_data[5:0])))
		else $error("bank a lane 0 not written");
	a_write_ack_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
		clk_en_i && wr_go && wr_hit_a |=> s_axi_bvalid_o && s_axi_bresp_o == pog_pkg::RESP_OKAY)
		else $error("bank a write not acknowledged");
	a_bad_write: assert property (@(posedge clk_i) disable iff (sys_rst_i)
		clk_en_i && wr_go && !wr_hit_a && !wr_hit_b
		|=> $stable(lane) && s_axi_bresp_o == pog_pkg::RESP_SLVERR)
		else $error("unmapped write not refused");
	// Answers retire once taken; a low enable holds everything except reset
	a_read_retire: assert property (@(posedge clk_i) disable iff (sys_rst_i)
		clk_en_i && s_axi_rvalid_o && s_axi_rready_i |=> !s_axi_rvalid_o)
		else $error("read answer not retired");
	a_write_retire: assert property (@(posedge clk_i) disable iff (sys_rst_i)
		clk_en_i && s_axi_bvalid_o && s_axi_bready_i |=> !s_axi_bvalid_o)
		else $error("write answer not retired");
	a_freeze_hold: assert property (@(posedge clk_i) disable iff (sys_rst_i)
		!sys_rst_i && !clk_en_i |=> $stable(pad_ctl_o) && $stable(lane))
		else $error("state moved while enable low");
	c_write_a: cover property (@(posedge clk_i) clk_en_i && wr_go && wr_hit_a);
	c_read_b: cover property (@(posedge clk_i) ar_take && rd_hit_b);
	c_bad_addr: cover property (@(posedge clk_i) s_axi_bvalid_o && s_axi_bresp_o == pog_pkg::RESP_SLVERR);
	c_frozen: cover property (@(posedge clk_i) !clk_en_i ##1 !clk_en_i);
	c_test1_drive: cover property (@(posedge clk_i) lane[7].software_override && pad_ctl_o[7].drive_oe);
endmodule

// [rtl/pog_pkg.sv]
/*
 Shared constants and types for the pad override bank.
 Assumes one 100 MHz register clock and an AXI4-Lite register bus.
*/
package pog_pkg;
	localparam int unsigned NUM_PADS     = 8;
	localparam int unsigned LANE_W       = 8;
	localparam logic [7:0] IDX_BANK_A    = 8'ha4;
	localparam logic [7:0] IDX_BANK_B    = 8'ha5;
	localparam logic [9:0] ADDR_BANK_A   = {IDX_BANK_A, 2'b00};
	localparam logic [9:0] ADDR_BANK_B   = {IDX_BANK_B, 2'b00};
	localparam int unsigned BIT_OE       = 0;
	localparam int unsigned BIT_LEVEL    = 1;
	localparam int unsigned BIT_OVR      = 2;
	localparam int unsigned BIT_PU_OFF   = 3;
	localparam int unsigned BIT_PD       = 4;
	localparam int unsigned BIT_SCHMITT  = 5;
	localparam int unsigned BIT_SAMPLED  = 6;
	localparam logic [6:0] LANE_RESET    = 7'h28;
	localparam logic [6:0] LANE_WR_MASK  = 7'h3f;
	localparam logic [1:0] RESP_OKAY     = 2'h0;
	localparam logic [1:0] RESP_SLVERR   = 2'h2;

	typedef struct packed {
		logic schmitt_enable;
		logic weak_pulldown_ctl;
		logic weak_pullup_off;
		logic software_override;
		logic output_level;
		logic drive_enable;
	} pog_lane_t;

	typedef struct packed {
		logic drive_oe;
		logic drive_level;
		logic pullup_en;
		logic pulldown_en;
		logic schmitt_en;
	} pog_pad_ctl_t;
endpackage

// [tb/pog_pad_board.sv]
/*
 Board model behind the eight pads.
 Assumes controls come from the bank; ext_i is the board's own level.
*/
`timescale 1ns/1ps
module pog_pad_board (
	// Pad cell controls
	input  wire pog_pkg::pog_pad_ctl_t [7:0] ctl_i,
	// Board level and resulting pad level
	input  wire logic [7:0]                  ext_i,
	output logic [7:0]                       pad_o
);
	// Own driver wins, then weak pull-up, then weak pull-down, else the board
	always_comb begin
		for (int p = 0; p < 8; p++) begin
			pad_o[p] = ctl_i[p].drive_oe ? ctl_i[p].drive_level :
				ctl_i[p].pullup_en ? 1'b1 : ctl_i[p].pulldown_en ? 1'b0 : ext_i[p];
		end
	end
endmodule

// [tb/tb_top.sv]
/*
 Random and corner register traffic for the pad override bank.
 Assumes the board model on the pads and an AXI4-Lite slave port.
*/
`timescale 1ns/1ps
module tb_top;
	logic                        clk_i = 1'b0;
	logic                        sys_rst_i = 1'b1;
	logic                        clk_en = 1'b1;
	logic [9:0]                  awaddr = 10'h000;
	logic [9:0]                  araddr = 10'h000;
	logic [31:0]                 wdata = 32'h0;
	logic [3:0]                  wstrb = 4'h0;
	logic                        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
	logic                        arvalid = 1'b0, rready = 1'b0;
	logic                        awready, wready, bvalid, arready, rvalid;
	logic [1:0]                  bresp, rresp;
	logic [31:0]                 rdata;
	logic [7:0]                  ext = 8'h00, pad_in;
	pog_pkg::pog_pad_ctl_t [7:0] nat = '0, ctl;
	logic [31:0]                 sh [2];
	int                          err_total = 0, n_tests = 0;
	integer                      seed = 32'h0d48c231;

	always #5 clk_i = ~clk_i;

	pog_bank i_pog_bank (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .clk_en_i(clk_en),
		.s_axi_awaddr_i(awaddr), .s_axi_awvalid_i(awvalid), .s_axi_awready_o(awready),
		.s_axi_wdata_i(wdata), .s_axi_wstrb_i(wstrb), .s_axi_wvalid_i(wvalid),
		.s_axi_wready_o(wready), .s_axi_bresp_o(bresp), .s_axi_bvalid_o(bvalid),
		.s_axi_bready_i(bready), .s_axi_araddr_i(araddr), .s_axi_arvalid_i(arvalid),
		.s_axi_arready_o(arready), .s_axi_rdata_o(rdata), .s_axi_rresp_o(rresp),
		.s_axi_rvalid_o(rvalid), .s_axi_rready_i(rready), .pad_in_i(pad_in),
		.native_ctl_i(nat), .pad_ctl_o(ctl));
	pog_pad_board i_pog_pad_board (.ctl_i(ctl), .ext_i(ext), .pad_o(pad_in));

	task automatic wrap_up();
		$display("comparisons %0d mismatches %0d", n_tests, err_total);
		if (err_total == 0 && n_tests > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask

	task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
		n_tests++;
		if (got !== exp) begin
			err_total++;
			$display("unexpected at %0t: %s got %h expected %h", $time, what, got, exp);
		end
	endtask

	task automatic stuck();
		err_total++;
		$display("unexpected at %0t: bus answer never came", $time);
		wrap_up();
	endtask

	task automatic axi_wr(input logic [9:0] a, input logic [31:0] d, input logic [3:0] s,
			output logic [1:0] resp);
		int n;
		@(posedge clk_i);
		awaddr <= a;
		wdata <= d;
		wstrb <= s;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		for (n = 0; n < 100; n++) begin
			@(posedge clk_i);
			if (awvalid && awready)
				awvalid <= 1'b0;
			if (wvalid && wready)
				wvalid <= 1'b0;
			if (bvalid)
				break;
		end
		if (n == 100)
			stuck();
		resp = bresp;
		bready <= 1'b0;
	endtask

	task automatic axi_rd(input logic [9:0] a, output logic [31:0] d, output logic [1:0] resp);
		int n;
		@(posedge clk_i);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		for (n = 0; n < 100; n++) begin
			@(posedge clk_i);
			if (arvalid && arready)
				arvalid <= 1'b0;
			if (rvalid)
				break;
		end
		if (n == 100)
			stuck();
		d = rdata;
		resp = rresp;
		rready <= 1'b0;
	endtask

	// Pad control a lane should produce, override on or off
	function automatic pog_pkg::pog_pad_ctl_t exp_ctl(int p);
		logic [7:0] l;
		l = sh[p/4][8*(p%4) +: 8];
		return l[2] ? pog_pkg::pog_pad_ctl_t'({l[0], l[1], ~l[3], l[4], l[5]}) : nat[p];
	endfunction

	function automatic logic exp_lvl(int p);
		pog_pkg::pog_pad_ctl_t c;
		c = exp_ctl(p);
		return c.drive_oe ? c.drive_level : c.pullup_en ? 1'b1 : c.pulldown_en ? 1'b0 : ext[p];
	endfunction

	function automatic logic [31:0] exp_rd(int b);
		logic [31:0] v;
		v = sh[b] & 32'h3f3f3f3f;
		for (int k = 0; k < 4; k++)
			v[8*k+6] = exp_lvl(b*4+k);
		return v;
	endfunction

	task automatic settle_chk();
		logic [31:0] d;
		logic [1:0]  r;
		repeat (5) @(posedge clk_i);
		for (int b = 0; b < 2; b++) begin
			axi_rd(b ? pog_pkg::ADDR_BANK_B : pog_pkg::ADDR_BANK_A, d, r);
			check(d, exp_rd(b), "lane readback");
			check({30'h0, r}, {30'h0, pog_pkg::RESP_OKAY}, "read response");
		end
		for (int p = 0; p < 8; p++)
			check({27'h0, ctl[p]}, {27'h0, exp_ctl(p)}, "pad control");
	endtask

	initial begin
		logic [31:0] d;
		logic [3:0]  s;
		logic [1:0]  r;
		int          b;
		pog_pkg::pog_pad_ctl_t [7:0] held;
		sh[0] = {4{8'h28}};
		sh[1] = {4{8'h28}};
		repeat (16) @(posedge clk_i);
		sys_rst_i <= 1'b0;
		settle_chk();
		$display("test reset values done");
		for (int i = 0; i < 40; i++) begin
			b = $random(seed) & 1;
			d = i == 1 ? 32'hffffffff : i == 2 ? 32'h0 : $random(seed);
			s = i < 4 ? 4'hf : 4'($random(seed));
			ext <= 8'($random(seed));
			nat <= 40'({$random(seed), $random(seed)});
			axi_wr(b ? pog_pkg::ADDR_BANK_B : pog_pkg::ADDR_BANK_A, d, s, r);
			check({30'h0, r}, {30'h0, pog_pkg::RESP_OKAY}, "write response");
			for (int k = 0; k < 4; k++)
				if (s[k])
					sh[b][8*k +: 8] = d[8*k +: 8] & 8'h3f;
			settle_chk();
		end
		$display("test random lanes done");
		axi_wr(10'h298, 32'hffffffff, 4'hf, r);
		check({30'h0, r}, {30'h0, pog_pkg::RESP_SLVERR}, "unmapped write");
		axi_rd(10'h000, d, r);
		check(d, 32'h0, "unmapped read data");
		check({30'h0, r}, {30'h0, pog_pkg::RESP_SLVERR}, "unmapped read");
		settle_chk();
		$display("test unmapped done");
		// Enable low: pad controls must hold although native inputs move
		@(posedge clk_i);
		clk_en <= 1'b0;
		for (int p = 0; p < 8; p++)
			held[p] = exp_ctl(p);
		nat <= ~nat;
		repeat (4) @(posedge clk_i);
		for (int p = 0; p < 8; p++)
			check({27'h0, ctl[p]}, {27'h0, held[p]}, "frozen pad control");
		clk_en <= 1'b1;
		settle_chk();
		$display("test clock enable done");
		@(posedge clk_i);
		sys_rst_i <= 1'b1;
		repeat (2) @(posedge clk_i);
		sys_rst_i <= 1'b0;
		sh[0] = {4{8'h28}};
		sh[1] = {4{8'h28}};
		settle_chk();
		$display("test second reset done");
		wrap_up();
	end
endmodule
